// >>> mobf_formatter.sv
// Output buffer loader and talker for the meter command path
//
// Contract
// - Commands execute in arrival order
// - Buffer loads only on output command or error
// - Queries, triggers and continuous mode produce output
// - Whole input string handled before buffer load
// - New buffer string sets data available
// - Transmit only while addressed as talker
// - Exponent multiple of three, point as displayed
// - Numeric length 11, or 16 with suffix
// - Suffix only on numeric data
// - Terminators selectable, default CR LF EOI
// - Overrange reading gives fixed signed value
// - Error string carries code, never suffix
// - Only rear milliamp error latches
// - Errors raise the any-error flag
// - Message 16, mask 2, others 4 characters
// - Some status prefixed by one or ten
// - Status captured when query executes
// - One string: status, then error, then numeric
// - Status leaves error pending for numeric
// - Fast rate zeroes last digit
// - New string makes pending output unreadable
// - Read once unless continuous mode reloads
// - Read end or terminator clears data available
`timescale 1ns/1ps
module mobf_formatter
  import mobf_pkg::*;
(
  input  wire logic         CORE_CLK,        // 100 MHz core clock
  input  wire logic         SYS_RST,         // Synchronous, active high
  input  wire logic         CMD_VALID,       // Command strobe
  input  wire logic [2:0]   CMD_CODE,        // Command kind
  input  wire logic [3:0]   CMD_ARG,         // Command argument
  input  wire logic         STR_END,         // Input terminator taken
  input  wire logic         TALK_ACTIVE,     // Addressed as talker
  input  wire logic         TX_READY,        // Bus accepts a byte
  input  wire logic         READING_STROBE,  // New continuous reading
  input  wire logic         READING_NEG,     // Reading sign
  input  wire logic [23:0]  READING_BCD,     // Six BCD digits
  input  wire logic [2:0]   READING_DP,      // Point position
  input  wire logic [1:0]   READING_EXP,     // Exponent code
  input  wire logic [39:0]  UNIT_SUFFIX,     // Five suffix characters
  input  wire logic [15:0]  STATUS_BCD,      // Status word, four BCD
  input  wire logic [1:0]   STATUS_PFX,      // Status prefix code
  input  wire logic [7:0]   SRQ_MASK_BCD,    // Service mask, two BCD
  input  wire logic [127:0] USER_MSG,        // Sixteen characters
  input  wire logic         ERR_EVENT,       // Error detected
  input  wire logic [7:0]   ERR_CODE,        // Error code, two BCD
  input  wire logic         REAR_MA_FAULT,   // Milliamp on rear input
  input  wire logic         FUNC_CHANGE,     // Function reselected
  output logic              TX_VALID,        // Byte offered
  output logic      [7:0]   TX_DATA,         // Byte on offer
  output logic              TX_EOI,          // Byte is last, with EOI
  output logic              DATA_AVAIL,      // Data available flag
  output logic              ANY_ERROR        // Any error flag
);

  // Command decode; every input here is on CORE_CLK, so unsynchronised
  wire cmd_query = CMD_VALID && (CMD_CODE == CMD_QUERY);
  wire cmd_trig  = CMD_VALID &&
                   ((CMD_CODE == CMD_TRIG) || (CMD_CODE == CMD_GET));
  wire cmd_tmode = CMD_VALID && (CMD_CODE == CMD_TMODE);
  wire cmd_sfx   = CMD_VALID && (CMD_CODE == CMD_SFX);
  wire cmd_term  = CMD_VALID && (CMD_CODE == CMD_TERM);
  wire cmd_rate  = CMD_VALID && (CMD_CODE == CMD_RATE);
  // Numeric query behaves like a request for a reading
  wire num_query = cmd_query && (CMD_ARG == QRY_NUMERIC);
  // Query numbers above the last one are dropped here
  wire sta_query = cmd_query && (CMD_ARG != QRY_NUMERIC) &&
                   (CMD_ARG <= QRY_LAST);

  // Configuration set by commands
  logic       sfx_en_reg;        // Suffix enable
  logic       fast_reg;          // Fast reading rate
  logic       cont_reg;          // Continuous trigger mode
  logic [2:0] term_reg;          // Terminator select

  // Requests gathered while a string is handled
  logic         qry_pend_reg;    // Status query seen
  logic [127:0] qry_data_reg;    // Status string snapshot
  logic [4:0]   qry_len_reg;     // Status string length
  logic         num_req_reg;     // Numeric data requested
  logic         rd_neg_reg;      // Reading snapshot: sign
  logic [23:0]  rd_bcd_reg;      // Reading snapshot: digits
  logic [2:0]   rd_dp_reg;       // Reading snapshot: point
  logic [1:0]   rd_exp_reg;      // Reading snapshot: exponent
  logic         rd_fast_reg;     // Rate at trigger time
  logic         rd_sfx_reg;      // Suffix setting at trigger time
  logic [39:0]  rd_unit_reg;     // Suffix text at trigger time

  // Error state
  logic         err_pend_reg;    // Error awaiting delivery
  logic         err_new_reg;     // Error arose in this string
  logic [7:0]   err_code_reg;    // Code to report

  // Output buffer, held as a shift register so TX_DATA is a flop
  logic [7:0]   buf_reg [BUF_DEPTH];
  logic [4:0]   cnt_reg;         // Characters left to send
  logic         eoi_en_reg;      // Mark the last byte with EOI
  logic         avail_reg;       // Data available
  logic         anyerr_reg;      // Any error
  mobf_state_t  state_reg;
  mobf_state_t  state_next;

  // Status string built from live inputs at query time
  logic [127:0] sta_chars;
  logic [4:0]   sta_len;
  always_comb begin
    sta_chars = '0;
    sta_len   = 5'(STAT_LEN);
    if (CMD_ARG == QRY_MESSAGE) begin
      sta_chars = USER_MSG;
      sta_len   = 5'(MSG_LEN);
    end else if (CMD_ARG == QRY_MASK) begin
      sta_chars[7:0]  = mobf_digit(SRQ_MASK_BCD[7:4]);
      sta_chars[15:8] = mobf_digit(SRQ_MASK_BCD[3:0]);
      sta_len         = 5'(MASK_LEN);
    end else begin
      // Prefix keeps leading zeros from being dropped by the host
      sta_chars[7:0]   = mobf_digit(STATUS_BCD[15:12]);
      sta_chars[15:8]  = mobf_digit(STATUS_BCD[11:8]);
      sta_chars[23:16] = mobf_digit(STATUS_BCD[7:4]);
      sta_chars[31:24] = mobf_digit(STATUS_BCD[3:0]);
      if (STATUS_PFX == PFX_ONE) begin
        sta_chars[7:0]  = CH_1;
      end else if (STATUS_PFX == PFX_TEN) begin
        sta_chars[7:0]  = CH_1;
        sta_chars[15:8] = CH_0;
      end
    end
  end

  // A continuous reading is refused in the load cycle and beside a
  // terminator, so it cannot collide with a string's own load
  // Load triggers: end of string, or a reading in continuous mode
  wire cont_load  = READING_STROBE && cont_reg && (state_reg == ST_IDLE)
                    && !STR_END;
  // Priority: status, then error, then numeric
  wire want_num   = num_req_reg || cont_load;
  wire ld_status  = qry_pend_reg;
  wire ld_error   = !qry_pend_reg && err_pend_reg &&
                    (err_new_reg || want_num);
  wire ld_numeric = !qry_pend_reg && !err_pend_reg && want_num;
  // Load only for an output command or an error
  wire do_load    = ((state_reg == ST_LOAD) || cont_load) &&
                    (ld_status || ld_error || ld_numeric);

  // The error select steers the formatter, so errors get no suffix
  // Numeric formatter sees the snapshot, or live data in continuous mode
  logic [127:0] num_chars;
  logic [4:0]   num_len;
  mobf_numfmt u_numfmt (
    .neg      (cont_load ? READING_NEG : rd_neg_reg),
    .digits   (cont_load ? READING_BCD : rd_bcd_reg),
    .dp_pos   (cont_load ? READING_DP  : rd_dp_reg),
    .exp_code (cont_load ? READING_EXP : rd_exp_reg),
    .fast     (cont_load ? fast_reg    : rd_fast_reg),
    .is_err   (ld_error),
    .err_code (err_code_reg),
    .sfx_en   (cont_load ? sfx_en_reg  : rd_sfx_reg),
    .sfx      (cont_load ? UNIT_SUFFIX : rd_unit_reg),
    .chars    (num_chars),
    .len      (num_len)
  );

  // With CR dropped LF comes first; with both dropped the last
  // body byte carries EOI alone
  // Body and terminators chosen at load time
  wire [127:0] body     = ld_status ? qry_data_reg : num_chars;
  wire [4:0]   body_len = ld_status ? qry_len_reg  : num_len;
  wire [143:0] body_ext = {16'h0000, body};  // Padded to buffer depth
  wire         use_cr   = !term_reg[TERM_NO_CR];
  wire         use_lf   = !term_reg[TERM_NO_LF];
  wire [4:0]   term_len = 5'({1'b0, use_cr} + {1'b0, use_lf});
  wire [7:0]   term_ch0 = use_cr ? CH_CR : CH_LF;
  wire [4:0]   tot_len  = body_len + term_len;

  // TX_VALID falls with the count, so nothing follows the last byte;
  // a stalling listener just sees the same byte held
  // Talker handshake: only when addressed to talk
  assign TX_VALID   = TALK_ACTIVE && avail_reg && (cnt_reg != 5'h0);
  wire   tx_take    = TX_VALID && TX_READY;
  wire   tx_last    = tx_take && (cnt_reg == 5'h1);
  assign TX_DATA    = buf_reg[0];
  assign TX_EOI     = eoi_en_reg && (cnt_reg == 5'h1);
  assign DATA_AVAIL = avail_reg;
  assign ANY_ERROR  = anyerr_reg;

  // LOAD lasts one cycle; a command sent in it belongs to the next
  // string, so the sender must leave that cycle empty
  // Loader moves to LOAD only once the whole string is taken
  assign state_next = STR_END ? ST_LOAD : ST_IDLE;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // An earlier trigger has already copied rate and suffix, so a later
  // change to them in the same string never reaches that reading
  // Configuration commands act in order, after any earlier trigger
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sfx_en_reg <= SFX_RST;
      fast_reg   <= FAST_RST;
      cont_reg   <= CONT_RST;
      term_reg   <= TERM_RST;
    end else begin
      if (cmd_sfx)   sfx_en_reg <= CMD_ARG[0];
      if (cmd_rate)  fast_reg   <= CMD_ARG[0];
      if (cmd_tmode) cont_reg   <= (CMD_ARG == 4'h0);
      if (cmd_term)  term_reg   <= CMD_ARG[2:0];
    end
  end

  // Query snapshot at its own place in the string
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      qry_pend_reg <= 1'b0;
      qry_data_reg <= '0;
      qry_len_reg  <= 5'h0;
    end else if (sta_query) begin
      qry_pend_reg <= 1'b1;
      qry_data_reg <= sta_chars;
      qry_len_reg  <= sta_len;
    end else if (state_reg == ST_LOAD) begin
      qry_pend_reg <= 1'b0;
    end
  end

  // Reading snapshot at trigger time, so later settings wait
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      num_req_reg <= 1'b0;
      rd_neg_reg  <= 1'b0;
      rd_bcd_reg  <= '0;
      rd_dp_reg   <= 3'h0;
      rd_exp_reg  <= EXP_P0;
      rd_fast_reg <= FAST_RST;
      rd_sfx_reg  <= SFX_RST;
      rd_unit_reg <= '0;
    end else if (cmd_trig || num_query) begin
      num_req_reg <= 1'b1;
      rd_neg_reg  <= READING_NEG;
      rd_bcd_reg  <= READING_BCD;
      rd_dp_reg   <= READING_DP;
      rd_exp_reg  <= READING_EXP;
      rd_fast_reg <= fast_reg;
      rd_sfx_reg  <= sfx_en_reg;
      rd_unit_reg <= UNIT_SUFFIX;
    end else if (state_reg == ST_LOAD) begin
      num_req_reg <= 1'b0;
    end
  end

  // Trade-off: error 31 follows the fault level, so once the fault
  // goes it is still reported one more time before it drops
  // Error capture; only the rear milliamp error survives delivery
  wire err_keep = (err_code_reg == ERR_LATCH_CODE) && REAR_MA_FAULT &&
                  !FUNC_CHANGE;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      err_pend_reg <= 1'b0;
      err_new_reg  <= 1'b0;
      err_code_reg <= 8'h00;
    end else if (ERR_EVENT) begin
      // A new error wins over a clear in the same cycle
      err_pend_reg <= 1'b1;
      err_new_reg  <= 1'b1;
      err_code_reg <= ERR_CODE;
    end else begin
      if (do_load && ld_error) begin
        err_pend_reg <= err_keep;
      end else if (FUNC_CHANGE &&
                   (err_code_reg == ERR_LATCH_CODE)) begin
        err_pend_reg <= 1'b0;
      end
      // Status delivery leaves the error pending
      if (state_reg == ST_LOAD) begin
        err_new_reg <= 1'b0;
      end
    end
  end

  // Shifting, not indexing, keeps TX_DATA a plain flop output
  // Buffer: load whole string, or shift one byte per handshake
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cnt_reg    <= 5'h0;
      eoi_en_reg <= 1'b0;
      for (int i = 0; i < BUF_DEPTH; i++) buf_reg[i] <= 8'h00;
    end else if (do_load) begin
      // Single output string per input string; new data overwrites
      cnt_reg    <= tot_len;
      eoi_en_reg <= !term_reg[TERM_NO_EOI];
      for (int i = 0; i < BUF_DEPTH; i++) begin
        if (5'(i) < body_len)       buf_reg[i] <= body_ext[8*i +: 8];
        else if (5'(i) == body_len) buf_reg[i] <= term_ch0;
        else                        buf_reg[i] <= CH_LF;
      end
    end else if (tx_take) begin
      // Characters leave in order, terminators last
      cnt_reg <= cnt_reg - 5'h1;
      for (int i = 0; i < BUF_DEPTH - 1; i++) begin
        buf_reg[i] <= buf_reg[i+1];
      end
      buf_reg[BUF_DEPTH-1] <= 8'h00;
    end else if (STR_END) begin
      cnt_reg <= 5'h0;
    end
  end

  // A load in the same cycle as a clear wins, so fresh data survives
  // Data available: set on load, cleared by read end or terminator
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      avail_reg <= 1'b0;
    end else if (do_load) begin
      avail_reg <= 1'b1;
    end else if (tx_last || STR_END) begin
      // Second read is ignored until a reload
      avail_reg <= 1'b0;
    end
  end

  // The flag may drop while an error still waits for a numeric request
  // Any error: set by an error, cleared by new string or read end
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      anyerr_reg <= 1'b0;
    end else if (ERR_EVENT || (do_load && ld_error)) begin
      anyerr_reg <= 1'b1;
    end else if (tx_last || STR_END) begin
      anyerr_reg <= 1'b0;
    end
  end

endmodule // mobf_formatter

// >>> mobf_pkg.sv
// Shared constants and types for the meter output buffer formatter
package mobf_pkg;

  // String lengths, terminators excluded
  localparam int NUM_LEN     = 11;   // Numeric string, suffix off
  localparam int SFX_LEN     = 5;    // Unit suffix characters
  localparam int NUM_SFX_LEN = 16;   // Numeric string, suffix on
  localparam int MSG_LEN     = 16;   // User message query answer
  localparam int MASK_LEN    = 2;    // Service mask query answer
  localparam int STAT_LEN    = 4;    // Any other status query answer
  localparam int BUF_DEPTH   = 18;   // Longest body plus CR and LF

  // ASCII characters used by the formatters
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_1     = 8'h31;
  localparam logic [7:0] CH_2     = 8'h32;
  localparam logic [7:0] CH_3     = 8'h33;
  localparam logic [7:0] CH_6     = 8'h36;
  localparam logic [7:0] CH_9     = 8'h39;
  localparam logic [7:0] CH_DOT   = 8'h2E;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_SP    = 8'h20;

  // Leading BCD digit at or above this means 200,000 counts or more
  localparam logic [3:0] OVR_DIGIT = 4'h2;
  // The one error code that latches (BCD)
  localparam logic [7:0] ERR_LATCH_CODE = 8'h31;
  // Query number that asks for a numeric reading
  localparam logic [3:0] QRY_NUMERIC = 4'h2;
  localparam logic [3:0] QRY_MASK    = 4'h1;
  localparam logic [3:0] QRY_MESSAGE = 4'h3;
  localparam logic [3:0] QRY_LAST    = 4'h8;

  // Exponent codes, each a multiple of three
  localparam logic [1:0] EXP_M3 = 2'h0;  // E-3
  localparam logic [1:0] EXP_P0 = 2'h1;  // E+0
  localparam logic [1:0] EXP_P3 = 2'h2;  // E+3
  localparam logic [1:0] EXP_P6 = 2'h3;  // E+6

  // Terminator select bits; a set bit removes that terminator
  localparam int TERM_NO_CR  = 0;
  localparam int TERM_NO_LF  = 1;
  localparam int TERM_NO_EOI = 2;

  // Values after reset
  localparam logic [2:0] TERM_RST = 3'h0;  // CR LF with EOI
  localparam logic       SFX_RST  = 1'b0;  // Suffix off
  localparam logic       FAST_RST = 1'b0;  // Slow rate
  localparam logic       CONT_RST = 1'b0;  // External trigger mode

  // Status prefix codes supplied with a status word
  localparam logic [1:0] PFX_NONE = 2'h0;
  localparam logic [1:0] PFX_ONE  = 2'h1;
  localparam logic [1:0] PFX_TEN  = 2'h2;

  // Commands handed over by the input interpreter
  typedef enum logic [2:0] {
    CMD_NOP   = 3'h0,
    CMD_QUERY = 3'h1,   // Status query, number in argument
    CMD_TRIG  = 3'h2,   // Single trigger
    CMD_GET   = 3'h3,   // Bus group execute trigger
    CMD_TMODE = 3'h4,   // Argument 0 continuous, else external
    CMD_SFX   = 3'h5,   // Argument bit 0 enables the suffix
    CMD_TERM  = 3'h6,   // Argument bits select terminators
    CMD_RATE  = 3'h7    // Argument bit 0 selects fast rate
  } mobf_cmd_t;

  // Loader state
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_LOAD = 1'b1
  } mobf_state_t;

  // Turn one BCD digit into its ASCII character
  function automatic logic [7:0] mobf_digit(input logic [3:0] d);
    return CH_0 | {4'h0, d};
  endfunction

endpackage

// >>> mobf_numfmt.sv
// Numeric, overrange and error string formatter
`timescale 1ns/1ps
module mobf_numfmt
  import mobf_pkg::*;
(
  input  wire logic         neg,       // Reading is negative
  input  wire logic [23:0]  digits,    // Six BCD digits, most first
  input  wire logic [2:0]   dp_pos,    // Digits left of the point
  input  wire logic [1:0]   exp_code,  // Exponent selector
  input  wire logic         fast,      // Fast rate reading
  input  wire logic         is_err,    // Format an error message
  input  wire logic [7:0]   err_code,  // Two BCD digits
  input  wire logic         sfx_en,    // Suffix enabled
  input  wire logic [39:0]  sfx,       // Suffix, first char low
  output logic      [127:0] chars,     // Char i at bits 8i+7..8i
  output logic      [4:0]   len        // Body length
);

  // Overrange when the count reaches 200,000
  wire         over    = (digits[23:20] >= OVR_DIGIT);
  // Fast rate forces the last digit to zero
  wire  [23:0] mant    = fast ? {digits[23:4], 4'h0} : digits;
  wire  [31:0] mpad    = {4'h0, mant, 4'h0};  // Padded for the selects
  wire  [7:0]  sgn_ch  = neg ? CH_MINUS : CH_PLUS;
  logic [7:0]  exp_ch;                  // Exponent digit
  logic [7:0]  exs_ch;                  // Exponent sign

  // Exponent always a multiple of three
  always_comb begin
    unique case (exp_code)
      EXP_M3: begin exs_ch = CH_MINUS; exp_ch = CH_3; end
      EXP_P0: begin exs_ch = CH_PLUS;  exp_ch = CH_0; end
      EXP_P3: begin exs_ch = CH_PLUS;  exp_ch = CH_3; end
      EXP_P6: begin exs_ch = CH_PLUS;  exp_ch = CH_6; end
    endcase
  end

  // Assemble the body string
  always_comb begin
    chars = '0;
    len   = 5'(NUM_LEN);
    if (is_err) begin
      // Error: fixed mantissa, code in it, suffix never added
      chars[7:0]    = CH_PLUS;
      chars[15:8]   = CH_1;
      chars[23:16]  = CH_DOT;
      chars[31:24]  = CH_0;
      chars[39:32]  = CH_0;
      chars[47:40]  = mobf_digit(err_code[7:4]);
      chars[55:48]  = mobf_digit(err_code[3:0]);
      chars[63:56]  = CH_E;
      chars[71:64]  = CH_PLUS;
      chars[79:72]  = CH_2;
      chars[87:80]  = CH_1;
    end else begin
      chars[7:0] = sgn_ch;
      if (over) begin
        // Fixed signed overrange value in every range
        chars[15:8]  = CH_9;
        chars[23:16] = CH_DOT;
        for (int i = 3; i < 8; i++) begin
          chars[8*i +: 8] = CH_9;
        end
        chars[79:72] = CH_PLUS;
        chars[87:80] = CH_9;
      end else begin
        // Point placed where the display shows it
        for (int i = 0; i < 7; i++) begin
          if (i == int'(dp_pos)) begin
            chars[8*(i+1) +: 8] = CH_DOT;
          end else if (i < int'(dp_pos)) begin
            chars[8*(i+1) +: 8] = mobf_digit(mpad[27-4*i -: 4]);
          end else begin
            chars[8*(i+1) +: 8] = mobf_digit(mpad[31-4*i -: 4]);
          end
        end
        chars[79:72] = exs_ch;
        chars[87:80] = exp_ch;
      end
      chars[71:64] = CH_E;
      // Suffix on numeric data only, giving 16 characters
      if (sfx_en) begin
        chars[127:88] = sfx;
        len           = 5'(NUM_SFX_LEN);
      end else begin
        chars[127:88] = '0;
        len           = 5'(NUM_LEN);
      end
    end
  end

endmodule // mobf_numfmt

// >>> mobf_formatter_props.sv
// Concurrent checks on the formatter's top-level ports
`timescale 1ns/1ps
module mobf_formatter_props (
  input wire logic       CORE_CLK,
  input wire logic       SYS_RST,
  input wire logic       STR_END,
  input wire logic       TALK_ACTIVE,
  input wire logic       TX_READY,
  input wire logic       READING_STROBE,
  input wire logic       ERR_EVENT,
  input wire logic       TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic       TX_EOI,
  input wire logic       DATA_AVAIL,
  input wire logic       ANY_ERROR
);
  // One clock domain, so one clocking and one disable
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  talk_gate_a: assert property (TX_VALID |-> TALK_ACTIVE)
    else $error("byte offered while not talker");
  talk_offer_a: assert property (DATA_AVAIL && TALK_ACTIVE |-> TX_VALID)
    else $error("talker with data but no byte");
  avail_cause_a: assert property ($rose(DATA_AVAIL) |->
    $past(STR_END, 2) || $past(READING_STROBE) || $past(READING_STROBE, 2))
    else $error("data available without a load cause");
  end_clear_a: assert property (STR_END |=> !DATA_AVAIL && !TX_VALID)
    else $error("string end left data readable");
  avail_gate_a: assert property (TX_VALID |-> DATA_AVAIL)
    else $error("byte offered with no data available");
  err_flag_a: assert property (ERR_EVENT |=> ANY_ERROR)
    else $error("error did not raise the flag");
  // A stalled byte must not change under the listener
  hold_byte_a: assert property (TX_VALID && !TX_READY && !STR_END &&
    !READING_STROBE |=> $stable(TX_DATA))
    else $error("byte changed before handshake");
  last_byte_a: assert property (TX_VALID && TX_READY && TX_EOI &&
    !READING_STROBE |=> !DATA_AVAIL)
    else $error("buffer still available after last byte");
endmodule // mobf_formatter_props

bind mobf_formatter mobf_formatter_props u_props (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .STR_END(STR_END),
  .TALK_ACTIVE(TALK_ACTIVE), .TX_READY(TX_READY),
  .READING_STROBE(READING_STROBE), .ERR_EVENT(ERR_EVENT),
  .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_EOI(TX_EOI),
  .DATA_AVAIL(DATA_AVAIL), .ANY_ERROR(ANY_ERROR));

// >>> mobf_ctrl_model.sv
// Bus controller model: addresses the talker and records its bytes
`timescale 1ns/1ps
module mobf_ctrl_model (
  input  wire logic       clk,
  input  wire logic       talk,      // Bench asks for a read
  input  wire logic       slow,      // Stall every other cycle
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_eoi,
  output logic            talk_active,
  output logic            tx_ready
);
  logic [7:0] rx [0:31];  // Bytes taken in this read
  int         n   = 0;    // Count of bytes taken
  logic       eoi = 1'b0; // End flag seen with the last byte
  initial talk_active = 1'b0;
  initial tx_ready = 1'b0;
  // Talk address first; bytes only move after it
  always @(posedge clk) begin
    talk_active <= talk;
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (talk && !talk_active) begin
      n <= 0;               // New read starts an empty record
    end else if (tx_valid && tx_ready && n < 32) begin
      rx[n] <= tx_data;
      n <= n + 1;
      eoi <= tx_eoi;
    end
  end
endmodule // mobf_ctrl_model

// >>> meter_output_buffer_formatter_bench.sv
// Self-checking bench for the output buffer formatter
`timescale 1ns/1ps
module meter_output_buffer_formatter_bench;
  import mobf_pkg::*;
  logic clk = 0, rst = 1, cv = 0, se = 0, talk = 0, slow = 0, rs = 0;
  logic neg = 0, ee = 0, ram = 0, fc = 0;
  logic [2:0] cc = 0, dp = 1;
  logic [3:0] ca = 0;
  logic [1:0] ex = EXP_P0, pf = PFX_NONE;
  logic [23:0] bcd = 0;
  logic [15:0] st = 0;
  logic [7:0] mk = 0, ec = 0;
  logic [127:0] msg = "PONMLKJIHGFEDCBA";  // Char 0 sits lowest
  logic [39:0] sfx = " CDV ";
  wire tv, te, da, ae, ta, tr;
  wire [7:0] td;
  int n_fail = 0, cmp_count = 0;

  initial forever #5 clk = ~clk;
  mobf_ctrl_model m (.clk(clk), .talk(talk), .slow(slow), .tx_valid(tv),
    .tx_data(td), .tx_eoi(te), .talk_active(ta), .tx_ready(tr));
  mobf_formatter DUT (.CORE_CLK(clk), .SYS_RST(rst), .CMD_VALID(cv),
    .CMD_CODE(cc), .CMD_ARG(ca), .STR_END(se), .TALK_ACTIVE(ta),
    .TX_READY(tr), .READING_STROBE(rs), .READING_NEG(neg),
    .READING_BCD(bcd), .READING_DP(dp), .READING_EXP(ex),
    .UNIT_SUFFIX(sfx), .STATUS_BCD(st), .STATUS_PFX(pf),
    .SRQ_MASK_BCD(mk), .USER_MSG(msg), .ERR_EVENT(ee), .ERR_CODE(ec),
    .REAR_MA_FAULT(ram), .FUNC_CHANGE(fc), .TX_VALID(tv), .TX_DATA(td),
    .TX_EOI(te), .DATA_AVAIL(da), .ANY_ERROR(ae));

  task chk(input logic [127:0] s, input logic [127:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task cmd(input logic [2:0] c, input logic [3:0] a);
    @(posedge clk) {cv, cc, ca} <= {1'b1, c, a};
    @(posedge clk) cv <= 0;
  endtask
  // Input terminator, then leave room for the load
  task fin;
    @(posedge clk) se <= 1;
    @(posedge clk) se <= 0;
    repeat (3) @(posedge clk);
  endtask
  task pulse_err(input logic [7:0] c);
    @(posedge clk) {ee, ec} <= {1'b1, c};
    @(posedge clk) ee <= 0;
  endtask
  // Address as talker, collect until the buffer empties, compare
  task rd(input string s, input logic eoi);
    int k;
    chk(tv, 0);  // Nothing offered before the talk address
    chk(da, s.len() > 0);  // Loaded data is flagged
    @(posedge clk) talk <= 1;
    for (k = 0; k < 60 && (da || k < 3); k++) @(posedge clk);
    talk <= 0;
    @(posedge clk);
    chk(m.n, s.len());
    for (k = 0; k < s.len(); k++) chk(m.rx[k], s[k]);
    if (s.len() > 0) chk(m.eoi, eoi);
  endtask
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Hang guard, well beyond the several hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk) bcd <= 24'h123456;
    chk(da, 0);
    cmd(CMD_TRIG, 0); fin; rd("+1.23456E+0\r\n", 1);
    rd("", 0);
    {neg, dp, ex} <= {1'b1, 3'h3, EXP_M3};
    cmd(CMD_SFX, 1); cmd(CMD_RATE, 1); cmd(CMD_TERM, 5);
    cmd(CMD_TRIG, 0); cmd(CMD_SFX, 0); cmd(CMD_RATE, 0); fin;
    slow <= 1;                                         // Listener stalls
    rd("-123.450E-3 VDC \n", 0);
    bcd <= 24'h234567;
    cmd(CMD_TERM, 0); cmd(CMD_GET, 0); fin; rd("-9.99999E+9\r\n", 1);
    {slow, neg, st} <= {1'b0, 1'b0, 16'h1234};
    pulse_err(8'h71); cmd(CMD_QUERY, 0);
    st <= 16'h9999;                          // Later change is not seen
    cmd(CMD_TRIG, 0); chk(ae, 1);
    fin; rd("1234\r\n", 1);
    pf <= PFX_TEN; cmd(CMD_QUERY, 4'h5); fin; rd("1099\r\n", 1);
    bcd <= 24'h100000;
    cmd(CMD_SFX, 1); cmd(CMD_TRIG, 0); fin; rd("+1.0071E+21\r\n", 1);
    cmd(CMD_TRIG, 0); fin; rd("+100.000E-3 VDC \r\n", 1);
    mk <= 8'h05;
    cmd(CMD_SFX, 0); cmd(CMD_QUERY, QRY_MASK); fin; rd("05\r\n", 1);
    cmd(CMD_QUERY, QRY_MESSAGE); fin; rd("ABCDEFGHIJKLMNOP\r\n", 1);
    cmd(CMD_TRIG, 0); fin; fin; chk(da, 0); rd("", 0);
    cmd(CMD_TMODE, 0); fin;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) rs <= 1;
      @(posedge clk) rs <= 0;
      repeat (3) @(posedge clk);
      rd("+100.000E-3\r\n", 1);
    end
    cmd(CMD_TMODE, 1); fin;
    ram <= 1;
    pulse_err(8'h31); cmd(CMD_TRIG, 0); fin; rd("+1.0031E+21\r\n", 1);
    cmd(CMD_TRIG, 0); fin; rd("+1.0031E+21\r\n", 1);
    @(posedge clk) {ram, fc} <= 2'b01;
    @(posedge clk) fc <= 0;
    cmd(CMD_TRIG, 0); fin; rd("+100.000E-3\r\n", 1);
    tally_and_finish;
  end
endmodule // meter_output_buffer_formatter_bench
